// ---- sht_pkg.sv ----
// package: op codes, hazard positions, instruction and strobe carriers, register map
`default_nettype none
package sht_pkg;

   ////////////////////////////////////////////////////////////////////////
   typedef enum logic [3:0] {
      SHT_OP_OTHER     = 4'h0,
      SHT_OP_MOVE_TO   = 4'h1,
      SHT_OP_MOVE_FROM = 4'h2,
      SHT_OP_XLAT_RD   = 4'h3,
      SHT_OP_XLAT_WI   = 4'h4,
      SHT_OP_XLAT_WR   = 4'h5,
      SHT_OP_XLAT_PRB  = 4'h6,
      SHT_OP_EXC_RET   = 4'h7,
      SHT_OP_TAG_RD    = 4'h8,
      SHT_OP_TAG_WR    = 4'h9,
      SHT_OP_CACHE_HIT = 4'hA,
      SHT_OP_LOAD_STORE = 4'hB
   } sht_op_e;

   typedef enum logic {
      SHT_VAR_FIRST  = 1'h0,
      SHT_VAR_SECOND = 1'h1
   } sht_variant_e;

   localparam int SHT_NUM_OP  = 12;
   localparam int SHT_MAX_POS = 6;
   typedef logic [2:0] sht_pos_t;

   ////////////////////////////////////////////////////////////////////////
   // per-op positions, indexed by op code; 0 means the op has no such step
   localparam sht_pos_t SHT_SRC_V1 [SHT_NUM_OP] =
      '{3'h0, 3'h0, 3'h3, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h0, 3'h3, 3'h3, 3'h3};
   localparam sht_pos_t SHT_DST_V1 [SHT_NUM_OP] =
      '{3'h0, 3'h5, 3'h0, 3'h5, 3'h5, 3'h5, 3'h6, 3'h4, 3'h5, 3'h0, 3'h5, 3'h0};
   localparam sht_pos_t SHT_SRC_V2 [SHT_NUM_OP] =
      '{3'h0, 3'h0, 3'h4, 3'h3, 3'h3, 3'h3, 3'h3, 3'h5, 3'h0, 3'h4, 3'h4, 3'h4};
   localparam sht_pos_t SHT_DST_V2 [SHT_NUM_OP] =
      '{3'h0, 3'h6, 3'h0, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h6, 3'h0, 3'h6, 3'h0};

   // fetch, interrupt and usable-test sampling, same in both variants; then exception write and shutdown positions
   localparam sht_pos_t SHT_MODE_POS      = 3'h2;
   localparam sht_pos_t SHT_FEXC_RET_V1   = 3'h4;
   localparam sht_pos_t SHT_FEXC_INFO_V1  = 3'h5;
   localparam sht_pos_t SHT_LSEXC_V1      = 3'h5;
   localparam sht_pos_t SHT_EXC_V2        = 3'h6;
   localparam sht_pos_t SHT_SHUT_INST_POS = 3'h2;
   localparam sht_pos_t SHT_SHUT_DATA_POS = 3'h4;

   ////////////////////////////////////////////////////////////////////////
   localparam int          SHT_ADDR_W       = 8;
   localparam logic [7:0]  SHT_CTRL_OFF     = 8'h00;
   localparam logic [7:0]  SHT_STATUS_OFF   = 8'h04;
   localparam logic [7:0]  SHT_STALLS_OFF   = 8'h08;
   localparam logic [7:0]  SHT_ISSUES_OFF   = 8'h0C;
   localparam logic [31:0] SHT_CTRL_RST     = 32'h00000001;
   localparam int          SHT_CTRL_EN_BIT  = 0;
   localparam int          SHT_ST_VAR_BIT   = 0;
   localparam int          SHT_ST_FAULT_BIT = 1;
   localparam int          SHT_ST_STALL_BIT = 2;
   localparam int          SHT_ST_SHUT_BIT  = 3;

   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic       valid;
      sht_op_e    op;
      logic       gpr_wr;
      logic [4:0] gpr_dst;
      logic [4:0] gpr_src_a;
      logic [4:0] gpr_src_b;
      logic       cop_use;
      logic       fetch_exc;
      logic       ls_exc;
      logic       shut_inst;
      logic       shut_data;
   } sht_instr_s;

   typedef struct packed {
      logic [SHT_NUM_OP-1:0] src_fix;
      logic [SHT_NUM_OP-1:0] dst_commit;
      logic                  fetch_fix;
      logic                  irq_sample;
      logic                  cu_check;
      logic                  exc_ret_wr;
      logic                  exc_info_wr;
      logic                  shutdown_set;
   } sht_strb_s;

endpackage
`default_nettype wire

// ---- sht_dep_check.sv ----
// general-register dependency and back-to-back move ordering check
`default_nettype none
module sht_dep_check (
   input  wire sht_pkg::sht_instr_s consumer,
   input  wire sht_pkg::sht_instr_s producer,
   output logic                     gpr_dep,
   output logic                     seq_fault
);
   import sht_pkg::*;

   // register zero is hardwired, so it never carries a dependency
   function automatic logic reads_gpr(sht_instr_s i, logic [4:0] r);
      return (r != 5'h00) && ((i.gpr_src_a == r) || (i.gpr_src_b == r));
   endfunction

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      // op kind plays no part: sysreg and buffer ops never lock
      gpr_dep = consumer.valid && producer.valid && producer.gpr_wr
                && reads_gpr(consumer, producer.gpr_dst); // RULE1 RULE2
      seq_fault = consumer.valid && producer.valid
                  && (consumer.op == SHT_OP_MOVE_FROM)
                  && (producer.op == SHT_OP_MOVE_TO); // RULE21
   end

endmodule // sht_dep_check
`default_nettype wire

// ---- sht_hazard_timing.sv ----
// system-register hazard timing pipeline with apb status and control
//
// Contract
// (RULE1) Stall issue when an instruction reads a register the previous one writes.
// (RULE2) No interlock at all for system register or translation buffer operations.
// (RULE3) Software spaces ops: destination position minus source position plus one.
// (RULE4) Sources usable once fixed, destinations once stored, at listed positions.
// (RULE5) First set: move_to_sysreg commits at 5, move_from_sysreg samples at 3.
// (RULE6) First set: xlat_read samples at 2, writes entry registers at 5.
// (RULE7) First set: buffer writes read sources at 2, update buffer at 5.
// (RULE8) First set: xlat_probe reads at 2, writes index register at 6.
// (RULE9) First set: exception_return reads at 2, clears level bits by 4.
// (RULE10) First set: tag read writes at 5, tag write reads 3, hits 3/5.
// (RULE11) First set: interrupt and usable-check inputs sampled at 2.
// (RULE12) First set: fetch state fixed at 2; fetch exception writes at 4 and 5.
// (RULE13) First set: loads and stores use state at 3, exceptions write at 5.
// (RULE14) Shutdown bit set at 2 for instruction side, 4 for data side; the code sets it in the first set only.
// (RULE15) Second set: moves commit 6, sample 4; xlat_read samples 3, writes 6.
// (RULE16) Second set: buffer writes read 3, update 6; probe reads 3, writes 6.
// (RULE17) Second set: exception_return reads at 5, changes level bits at 6.
// (RULE18) Second set: tag read writes 6, tag write reads 4, hits 4/6.
// (RULE19) Second set: usable check and fetch take mode state at 2.
// (RULE20) Second set: loads and stores use state at 4, exceptions write 6.
// (RULE21) Software never puts move_from_sysreg right after move_to_sysreg.
// (RULE22) Timing set is a build-time parameter, never changed while running.
//
// Local design decisions: the register addresses and the APB interface to the registers.
`default_nettype none
module sht_hazard_timing #(
   parameter sht_pkg::sht_variant_e VARIANT     = sht_pkg::SHT_VAR_FIRST,
   parameter bit                    SHUTDOWN_EN = 1'b1
) (
   input  wire logic                         pclk,
   input  wire logic                         presetn,
   input  wire logic                         clk_en,
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [sht_pkg::SHT_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   input  wire logic                         issue_valid,
   input  wire sht_pkg::sht_instr_s          issue_instr,
   output logic                              issue_ready,
   output logic                              gpr_stall,
   output sht_pkg::sht_strb_s                strb
);
   import sht_pkg::*;

   ////////////////////////////////////////////////////////////////////////
   // positions that depend only on the build-time timing set
   localparam bit       FIRST       = (VARIANT == SHT_VAR_FIRST); // RULE22
   localparam bit       SHUT_ON     = SHUTDOWN_EN && FIRST;
   localparam sht_pos_t FEXC_RET    = FIRST ? SHT_FEXC_RET_V1 : SHT_EXC_V2;
   localparam sht_pos_t FEXC_INFO   = FIRST ? SHT_FEXC_INFO_V1 : SHT_EXC_V2;
   localparam sht_pos_t LSEXC_POS   = FIRST ? SHT_LSEXC_V1 : SHT_EXC_V2;

   sht_instr_s  pipe      [1:SHT_MAX_POS];
   sht_instr_s  next_pipe [1:SHT_MAX_POS];
   sht_instr_s  in_instr;
   sht_strb_s   next_strb;
   logic        accept;
   logic        next_stall;
   logic        next_fault;
   logic        ctrl_en;
   logic        fault;
   logic [31:0] stall_cnt;
   logic [31:0] issue_cnt;
   logic [31:0] rd_data;
   logic        rd_hit;
   logic        apb_done;
   logic        wr_now;

   ////////////////////////////////////////////////////////////////////////
   function automatic sht_pos_t src_pos(sht_op_e op);
      return FIRST ? SHT_SRC_V1[op] : SHT_SRC_V2[op];
   endfunction

   function automatic sht_pos_t dst_pos(sht_op_e op);
      return FIRST ? SHT_DST_V1[op] : SHT_DST_V2[op];
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // position 1 is decode; only it is held on a stall, later positions always move while clk_en is high
   always_comb
   begin
      accept = issue_valid && issue_ready;
      in_instr = issue_instr;
      in_instr.valid = 1'b1;
      if (!gpr_stall)
      begin
         next_pipe[1] = accept ? in_instr : '0;
         next_pipe[2] = pipe[1];
      end
      else
      begin
         next_pipe[1] = pipe[1];
         next_pipe[2] = '0; // RULE1
      end
      for (int k = 3; k <= SHT_MAX_POS; k++)
      begin
         next_pipe[k] = pipe[k-1];
      end
   end

   // the pair that will sit in positions 1 and 2 after this edge
   sht_dep_check u_dep (
      .consumer  (next_pipe[1]),
      .producer  (next_pipe[2]),
      .gpr_dep   (next_stall),
      .seq_fault (next_fault)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int k = 1; k <= SHT_MAX_POS; k++)
         begin
            pipe[k] <= '0;
         end
      end
      else if (clk_en)
      begin
         pipe <= next_pipe;
      end
   end

   // ready is registered: it already knows whether the next cycle stalls
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         gpr_stall <= 1'b0;
         issue_ready <= 1'b0;
      end
      else if (clk_en)
      begin
         gpr_stall <= next_stall; // RULE1
         issue_ready <= ctrl_en && !next_stall;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // strobes mark the cycle an item is fixed or stored; no lock is derived
   always_comb
   begin
      next_strb = '0;
      for (int k = 1; k <= SHT_MAX_POS; k++)
      begin
         if (next_pipe[k].valid)
         begin
            if (src_pos(next_pipe[k].op) == 3'(k))
            begin
               next_strb.src_fix[next_pipe[k].op] = 1'b1; // RULE4 RULE5 RULE6 RULE7 RULE8 RULE9 RULE10 RULE15 RULE17 RULE18
            end
            if (dst_pos(next_pipe[k].op) == 3'(k))
            begin
               next_strb.dst_commit[next_pipe[k].op] = 1'b1; // RULE4 RULE6 RULE7 RULE8 RULE9 RULE10 RULE16 RULE17 RULE18
            end
            if (3'(k) == SHT_MODE_POS)
            begin
               next_strb.fetch_fix = 1'b1; // RULE12 RULE19
               next_strb.irq_sample = 1'b1; // RULE11
               next_strb.cu_check = next_pipe[k].cop_use; // RULE11 RULE19
            end
            if (next_pipe[k].fetch_exc && (3'(k) == FEXC_RET))
            begin
               next_strb.exc_ret_wr = 1'b1; // RULE12 RULE20
            end
            if (next_pipe[k].fetch_exc && (3'(k) == FEXC_INFO))
            begin
               next_strb.exc_info_wr = 1'b1; // RULE12 RULE20
            end
            if (next_pipe[k].ls_exc && (3'(k) == LSEXC_POS))
            begin
               next_strb.exc_ret_wr = 1'b1; // RULE13 RULE20
               next_strb.exc_info_wr = 1'b1; // RULE13
            end
            if (SHUT_ON && next_pipe[k].shut_inst && (3'(k) == SHT_SHUT_INST_POS))
            begin
               next_strb.shutdown_set = 1'b1; // RULE14
            end
            if (SHUT_ON && next_pipe[k].shut_data && (3'(k) == SHT_SHUT_DATA_POS))
            begin
               next_strb.shutdown_set = 1'b1; // RULE14
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         strb <= '0;
      end
      else if (clk_en)
      begin
         strb <= next_strb; // RULE4
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // spacing is software's job; a move pair is only reported, never fixed
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         fault <= 1'b0;
      end
      else if (clk_en)
      begin
         if (next_fault)
         begin
            fault <= 1'b1; // RULE3 RULE21
         end
         else if (wr_now && (paddr == SHT_STATUS_OFF) && pwdata[SHT_ST_FAULT_BIT])
         begin
            fault <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stall_cnt <= '0;
         issue_cnt <= '0;
      end
      else if (clk_en)
      begin
         if (next_stall)
         begin
            stall_cnt <= stall_cnt + 32'h00000001;
         end
         if (accept)
         begin
            issue_cnt <= issue_cnt + 32'h00000001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // apb slave: one wait state, so decode has a full cycle
   assign apb_done = psel && penable && pready;
   assign wr_now = apb_done && pwrite;

   always_comb
   begin
      rd_hit = 1'b1;
      rd_data = '0;
      if (paddr == SHT_CTRL_OFF)
      begin
         rd_data[SHT_CTRL_EN_BIT] = ctrl_en;
      end
      else if (paddr == SHT_STATUS_OFF)
      begin
         rd_data[SHT_ST_VAR_BIT] = !FIRST;
         rd_data[SHT_ST_FAULT_BIT] = fault;
         rd_data[SHT_ST_STALL_BIT] = gpr_stall;
         rd_data[SHT_ST_SHUT_BIT] = SHUT_ON;
      end
      else if (paddr == SHT_STALLS_OFF)
      begin
         rd_data = stall_cnt;
      end
      else if (paddr == SHT_ISSUES_OFF)
      begin
         rd_data = issue_cnt;
      end
      else
      begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
         prdata <= '0;
         pslverr <= 1'b0;
      end
      else if (clk_en)
      begin
         pready <= psel && penable && !pready;
         if (psel && penable && !pready)
         begin
            prdata <= pwrite ? 32'h00000000 : rd_data;
            pslverr <= !rd_hit;
         end
         else
         begin
            prdata <= '0;
            pslverr <= 1'b0;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl_en <= SHT_CTRL_RST[SHT_CTRL_EN_BIT];
      end
      else if (clk_en && wr_now && (paddr == SHT_CTRL_OFF))
      begin
         ctrl_en <= pwdata[SHT_CTRL_EN_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_stall_one_cycle: assert property ((clk_en && gpr_stall) |=> !gpr_stall) // RULE1
      else $error("interlock held for more than one cycle");

   a_stall_bubble: assert property ((clk_en && gpr_stall) |=> !pipe[2].valid) // RULE1
      else $error("no bubble inserted behind a stalled instruction");

   a_stall_only_gpr: assert property (gpr_stall |-> (pipe[2].valid && pipe[2].gpr_wr // RULE2
      && (pipe[2].gpr_dst != 5'h00)
      && ((pipe[1].gpr_src_a == pipe[2].gpr_dst) || (pipe[1].gpr_src_b == pipe[2].gpr_dst))))
      else $error("stall raised without a register dependency");

   a_move_to_commit: assert property ((clk_en && FIRST && pipe[4].valid // RULE5
      && (pipe[4].op == SHT_OP_MOVE_TO)) |=> strb.dst_commit[SHT_OP_MOVE_TO])
      else $error("move to sysreg did not commit at position 5");

   a_move_from_fix: assert property ((clk_en && FIRST && pipe[2].valid // RULE5
      && (pipe[2].op == SHT_OP_MOVE_FROM)) |=> strb.src_fix[SHT_OP_MOVE_FROM])
      else $error("move from sysreg did not sample at position 3");

   a_xlat_read_pair: assert property ((clk_en && FIRST && !gpr_stall && pipe[1].valid // RULE6
      && (pipe[1].op == SHT_OP_XLAT_RD)) ##1 clk_en [*3]
      |=> (strb.dst_commit[SHT_OP_XLAT_RD] && $past(strb.src_fix[SHT_OP_XLAT_RD], 3)))
      else $error("xlat read entry registers not written at position 5");

   a_probe_index: assert property ((clk_en && FIRST && pipe[5].valid // RULE8
      && (pipe[5].op == SHT_OP_XLAT_PRB)) |=> strb.dst_commit[SHT_OP_XLAT_PRB])
      else $error("probe result not written at position 6");

   a_exception_return_levels: assert property ((clk_en && FIRST && pipe[3].valid // RULE9
      && (pipe[3].op == SHT_OP_EXC_RET)) |=> strb.dst_commit[SHT_OP_EXC_RET])
      else $error("exception return level bits not changed at position 4");

   a_move_to_second: assert property ((clk_en && !FIRST && pipe[5].valid // RULE15
      && (pipe[5].op == SHT_OP_MOVE_TO)) |=> strb.dst_commit[SHT_OP_MOVE_TO])
      else $error("second set move to sysreg did not commit at position 6");

   a_tag_read_second: assert property ((clk_en && !FIRST && pipe[5].valid // RULE18
      && (pipe[5].op == SHT_OP_TAG_RD)) |=> strb.dst_commit[SHT_OP_TAG_RD])
      else $error("second set tag read not written at position 6");

   a_fetch_fix: assert property ((clk_en && !gpr_stall && pipe[1].valid) // RULE12
      |=> (strb.fetch_fix && strb.irq_sample))
      else $error("fetch state not fixed at position 2");

   a_shut_data: assert property ((clk_en && SHUT_ON && pipe[3].valid // RULE14
      && pipe[3].shut_data) |=> strb.shutdown_set)
      else $error("data side shutdown bit not set at position 4");

endmodule // sht_hazard_timing
`default_nettype wire

// ---- sysreg_hazard_timing_tb.sv ----
// self-checking bench: hazard strobes, gpr stalls and apb registers for both timing sets
`default_nettype none
module sysreg_hazard_timing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sht_pkg::*;

   // per-op positions, op 11 down to op 0: first src, first dst, second src, second dst
   localparam logic [47:0] POS_TAB [4] = '{48'h333022222300, 48'h050546555050,
                                           48'h444053333400, 48'h060666666060};
   logic        pclk;
   logic        presetn;
   logic        clk_en;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata [2];
   logic        pready [2];
   logic        pslverr [2];
   logic        issue_valid;
   sht_instr_s  issue_instr;
   logic        issue_ready [2];
   logic        gpr_stall [2];
   sht_strb_s   strb [2];
   sht_strb_s   exp_strb [2][int];
   bit          exp_stall [int];
   logic [65:0] apb_q [$];
   sht_instr_s  prev;
   int          error_cnt = 0;
   int          checks = 0;
   int          cyc = 0;
   int          stalls = 0;
   int          issued = 0;
   logic        fault = 1'b0;

   // instance 0 first set with shutdown, instance 1 second set without
   for (genvar g = 0; g < 2; g++)
   begin : g_dut
      sht_hazard_timing #(
         .VARIANT     (sht_variant_e'(g)),
         .SHUTDOWN_EN (1'(g == 0))
      ) dut (
         .pclk        (pclk),
         .presetn     (presetn),
         .clk_en      (clk_en),
         .psel        (psel),
         .penable     (penable),
         .pwrite      (pwrite),
         .paddr       (paddr),
         .pwdata      (pwdata),
         .prdata      (prdata[g]),
         .pready      (pready[g]),
         .pslverr     (pslverr[g]),
         .issue_valid (issue_valid),
         .issue_instr (issue_instr),
         .issue_ready (issue_ready[g]),
         .gpr_stall   (gpr_stall[g]),
         .strb        (strb[g])
      );
   end

   initial
   begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   always @(posedge pclk)
      cyc <= cyc + 1;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic final_report();
      $display("checks %0d error_cnt %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic hang();
      error_cnt++;
      final_report();
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   function automatic int pos(input int v, input int k, input sht_op_e o);
      logic [47:0] t;
      t = POS_TAB[2 * v + k];
      return int'(t[4 * o +: 4]);
   endfunction

   function automatic logic [63:0] stat();
      return {30'h0, fault, 1'b1, 28'h0, 1'b1, 1'b0, fault, 1'b0};
   endfunction

   task automatic put(input int v, input int c, input sht_strb_s s);
      if (!exp_strb[v].exists(c))
         exp_strb[v][c] = '0;
      exp_strb[v][c] = exp_strb[v][c] | s;
   endtask

   // notes every strobe one accepted instruction must raise, b is the accept edge, one later for an instruction that stalls
   task automatic expect_ins(input int v, input int b, input sht_instr_s ins);
      sht_strb_s s;
      s = '0;
      s.fetch_fix = 1'b1;
      s.irq_sample = 1'b1;
      s.cu_check = ins.cop_use;
      put(v, b + 2, s);
      s = '0;
      s.src_fix[ins.op] = 1'b1;
      if (pos(v, 0, ins.op) != 0)
         put(v, b + pos(v, 0, ins.op), s);
      s = '0;
      s.dst_commit[ins.op] = 1'b1;
      if (pos(v, 1, ins.op) != 0)
         put(v, b + pos(v, 1, ins.op), s);
      s = '0;
      s.exc_ret_wr = 1'b1;
      if (ins.fetch_exc)
         put(v, b + (v ? 6 : 4), s);
      if (ins.ls_exc)
         put(v, b + (v ? 6 : 5), s);
      s = '0;
      s.exc_info_wr = 1'b1;
      if (ins.fetch_exc || ins.ls_exc)
         put(v, b + (v ? 6 : 5), s);
      s = '0;
      s.shutdown_set = 1'b1;
      if (v == 0 && ins.shut_inst)
         put(v, b + 2, s);
      if (v == 0 && ins.shut_data)
         put(v, b + 4, s);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge pclk)
   begin
      logic [65:0] n;
      if (presetn === 1'b1)
      begin
         for (int v = 0; v < 2; v++)
         begin
            if (strb[v] !== '0 || exp_strb[v].exists(cyc))
               chk(strb[v], exp_strb[v].exists(cyc) ? exp_strb[v][cyc] : '0);
            if (exp_strb[v].exists(cyc))
               exp_strb[v].delete(cyc);
            if (gpr_stall[v] !== 1'b0 || exp_stall.exists(cyc))
               chk(gpr_stall[v], exp_stall.exists(cyc));
         end
         if (exp_stall.exists(cyc))
            exp_stall.delete(cyc);
         if (pready[0] === 1'b1 || pready[1] === 1'b1)
         begin
            n = (apb_q.size() > 0) ? apb_q.pop_front() : '1;
            for (int v = 0; v < 2; v++)
            begin
               chk(pready[v], 1'b1);
               chk(pslverr[v], n[64]);
               if (!n[65])
                  chk(prdata[v], v ? n[63:32] : n[31:0]);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [63:0] ed, input logic ee);
      int n;
      apb_q.push_back({wr, ee, ed});
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready[0] !== 1'b1 && n < 20);
      if (n >= 20)
         hang();
      psel    <= 1'b0;
      penable <= 1'b0;
      // idle edge keeps two requests from assigning psel in one step
      @(posedge pclk);
   endtask

   task automatic issue(input sht_instr_s ins);
      int   n;
      logic dep;
      issue_valid <= 1'b1;
      issue_instr <= ins;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (issue_ready[0] !== 1'b1 && n < 20);
      if (n >= 20)
         hang();
      dep = prev.gpr_wr && prev.gpr_dst != 5'h00 &&
            (prev.gpr_dst == ins.gpr_src_a || prev.gpr_dst == ins.gpr_src_b);
      if (dep)
         exp_stall[cyc + 1] = 1'b1;
      fault |= prev.op == SHT_OP_MOVE_TO && ins.op == SHT_OP_MOVE_FROM;
      stalls += int'(dep);
      issued++;
      for (int v = 0; v < 2; v++)
         expect_ins(v, cyc + int'(dep), ins);
      prev = ins;
   endtask

   function automatic sht_instr_s rnd_ins(input int o, input logic last);
      sht_instr_s r;
      r           = '0;
      r.valid     = 1'b1;
      r.op        = sht_op_e'(o);
      r.gpr_wr    = !last && $urandom_range(0, 1);
      r.gpr_dst   = 5'($urandom_range(0, 3));
      r.gpr_src_a = 5'($urandom_range(0, 3));
      r.gpr_src_b = 5'($urandom_range(0, 3));
      r.cop_use   = 1'($urandom_range(0, 1));
      r.fetch_exc = $urandom_range(0, 7) == 0;
      r.ls_exc    = o == 11 && !r.fetch_exc && $urandom_range(0, 2) == 0;
      r.shut_inst = $urandom_range(0, 7) == 0;
      r.shut_data = $urandom_range(0, 7) == 0;
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      int seed;
      presetn     = 1'b0;
      clk_en      = 1'b1;
      psel        = 1'b0;
      penable     = 1'b0;
      pwrite      = 1'b0;
      paddr       = 8'h00;
      pwdata      = 32'h0;
      issue_valid = 1'b0;
      issue_instr = '0;
      prev        = '0;
      seed = $urandom(32'hF127C594);
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, SHT_CTRL_OFF, 32'h0, {2{SHT_CTRL_RST}}, 1'b0);
      apb(1'b0, SHT_STATUS_OFF, 32'h0, stat(), 1'b0);
      apb(1'b0, 8'h10, 32'h0, 64'h0, 1'b0 | 1'b1);
      apb(1'b1, 8'h02, 32'h0, 64'h0, 1'b1);
      // every op once, back to back; move_to then move_from forms the pair
      for (int o = 0; o < SHT_NUM_OP; o++)
         issue(rnd_ins(o, 1'b1));
      for (int i = 0; i < 80; i++)
         issue(rnd_ins($urandom_range(0, SHT_NUM_OP - 1), i == 79));
      issue_valid <= 1'b0;
      repeat (8) @(posedge pclk);
      apb(1'b0, SHT_STALLS_OFF, 32'h0, {2{stalls}}, 1'b0);
      apb(1'b0, SHT_ISSUES_OFF, 32'h0, {2{issued}}, 1'b0);
      apb(1'b1, SHT_ISSUES_OFF, 32'h5A, 64'h0, 1'b0);
      apb(1'b0, SHT_ISSUES_OFF, 32'h0, {2{issued}}, 1'b0);
      apb(1'b0, SHT_STATUS_OFF, 32'h0, stat(), 1'b0);
      apb(1'b1, SHT_STATUS_OFF, 32'h2, 64'h0, 1'b0);
      fault = 1'b0;
      apb(1'b0, SHT_STATUS_OFF, 32'h0, stat(), 1'b0);
      // issue disable must hold off acceptance
      apb(1'b1, SHT_CTRL_OFF, 32'h0, 64'h0, 1'b0);
      repeat (2) @(posedge pclk);
      chk(issue_ready[0], 1'b0);
      chk(issue_ready[1], 1'b0);
      apb(1'b1, SHT_CTRL_OFF, 32'h1, 64'h0, 1'b0);
      apb(1'b0, SHT_CTRL_OFF, 32'h0, {2{32'h1}}, 1'b0);
      // offer while frozen: nothing may be taken or strobed
      clk_en      <= 1'b0;
      issue_valid <= 1'b1;
      repeat (3) @(posedge pclk);
      clk_en <= 1'b1;
      issue(rnd_ins(11, 1'b1));
      issue_valid <= 1'b0;
      repeat (10) @(posedge pclk);
      apb(1'b0, SHT_ISSUES_OFF, 32'h0, {2{issued}}, 1'b0);
      chk(exp_strb[0].size() + exp_strb[1].size() + exp_stall.size() + apb_q.size(), 0);
      final_report();
   end

endmodule // sysreg_hazard_timing_tb
`default_nettype wire
